/* core/ssp_pkg.sv */
// Package for the strap-sample and status-pin block.
// Assumes one 250 MHz clock and an APB register port with 32-bit data.
package ssp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STRAP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0c;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_W = 2;
  localparam int CTRL_LAMP_TEST = 0;
  localparam int CTRL_IRQ_PIN_EN = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h2;
  localparam int STRAP_ADDR_LSB = 0;
  localparam int STRAP_REF_BIT = 5;
  localparam int STRAP_ISO_BIT = 6;
  localparam int STRAP_FW_BIT = 7;
  localparam int EVT_W_DEF = 4;
  localparam int LAMP_N = 5;
  localparam int PHY_ADDR_W = 5;
  // Level driven on the address bit 0 pin after reset
  localparam logic ADDR0_RUN_LVL = 1'b0;

  // ----------------------------------------------------------------
  // Reference clock figures
  // ----------------------------------------------------------------
  localparam int FREQ_W = 18;
  localparam logic [FREQ_W-1:0] REF_XTAL_KHZ = 18'h2625a;
  localparam logic [FREQ_W-1:0] REF_EXT_KHZ = 18'h0c350;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {SSP_REF_EXT_50M, SSP_REF_XTAL_156M25} ssp_ref_t;
  typedef enum logic {SSP_PH_HOLD, SSP_PH_RUN} ssp_phase_t;

  typedef struct packed {
    logic [PHY_ADDR_W-1:0] phy_addr;
    ssp_ref_t ref_src;
    logic super_iso;
    logic fw_rom;
  } ssp_strap_t;

endpackage : ssp_pkg

/* core/ssp_strap_pins.sv */
// Shared strap / status-lamp / interrupt pins with an APB register port.
// Assumes pins are sampled synchronously to clk and that the board only
// places pull resistors on the shared pins.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module ssp_strap_pins
  import ssp_pkg::*;
#(
  parameter int EVT_W = EVT_W_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic phy_addr_strap0_i,
  output logic phy_addr_strap0_o,
  output logic phy_addr_strap0_oe,
  input wire logic [1:0] phy_addr_strap_mid,
  input wire logic status_lamp1_n_i,
  output logic status_lamp1_n_o,
  output logic status_lamp1_n_oe,
  input wire logic status_lamp2_n_i,
  output logic status_lamp2_n_o,
  output logic status_lamp2_n_oe,
  input wire logic status_lamp3_n_i,
  output logic status_lamp3_n_o,
  output logic status_lamp3_n_oe,
  input wire logic status_lamp4_n_i,
  output logic status_lamp4_n_o,
  output logic status_lamp4_n_oe,
  input wire logic status_lamp5_n_i,
  output logic status_lamp5_n_o,
  output logic status_lamp5_n_oe,
  input wire logic port_irq_n_i,
  output logic port_irq_n_o,
  output logic port_irq_n_oe,
  input wire logic [LAMP_N-1:0] lamp_on,
  input wire logic [EVT_W-1:0] evt,
  output ssp_strap_t straps,
  output logic [FREQ_W-1:0] ref_freq_khz,
  output logic super_isolate,
  output logic fw_from_rom,
  output logic fw_from_mgmt,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (EVT_W < 1 || EVT_W > 32) begin : g_bad_evt
    $error("EVT_W must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // Phase and strap capture
  // ----------------------------------------------------------------
  ssp_phase_t phase_q;
  logic run;
  ssp_strap_t straps_q;
  logic [FREQ_W-1:0] ref_freq_q;
  logic super_iso_q;
  logic fw_rom_q;
  logic fw_mgmt_q;
  logic [LAMP_N-1:0] lamp_q;
  logic [LAMP_N-1:0] lamp_oe;
  logic [CTRL_W-1:0] ctrl_q;
  logic [EVT_W-1:0] stat_q;
  logic [EVT_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic pending;

  assign run = (phase_q == SSP_PH_RUN);

  // Async reset parks the phase and zeroes the straps; the pins are read by the first
  // clock edge after release, never by the reset itself.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= SSP_PH_HOLD;
    end else begin
      case (phase_q)
        SSP_PH_HOLD: phase_q <= SSP_PH_RUN;
        SSP_PH_RUN: phase_q <= SSP_PH_RUN;
        default: phase_q <= SSP_PH_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      straps_q <= '0;
    end else if (phase_q == SSP_PH_HOLD) begin
      straps_q.phy_addr <= {status_lamp3_n_i, phy_addr_strap_mid,
                            status_lamp1_n_i, phy_addr_strap0_i};
      straps_q.ref_src <= status_lamp2_n_i ? SSP_REF_XTAL_156M25 : SSP_REF_EXT_50M;
      straps_q.super_iso <= status_lamp5_n_i;
      straps_q.fw_rom <= port_irq_n_i;
    end
  end

  assign straps = straps_q;

  // ----------------------------------------------------------------
  // Decoded strap effects
  // ----------------------------------------------------------------
  // Reference frequency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_freq_q <= '0;
    end else if (phase_q == SSP_PH_HOLD) begin
      ref_freq_q <= status_lamp2_n_i ? REF_XTAL_KHZ : REF_EXT_KHZ;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      super_iso_q <= 1'b0;
    end else if (phase_q == SSP_PH_HOLD) begin
      super_iso_q <= status_lamp5_n_i;
    end
  end

  // Firmware path, exactly one active once running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fw_rom_q <= 1'b0;
      fw_mgmt_q <= 1'b0;
    end else if (phase_q == SSP_PH_HOLD) begin
      fw_rom_q <= port_irq_n_i;
      fw_mgmt_q <= ~port_irq_n_i;
    end
  end

  assign ref_freq_khz = ref_freq_q;
  assign super_isolate = super_iso_q;
  assign fw_from_rom = fw_rom_q;
  assign fw_from_mgmt = fw_mgmt_q;

  // ----------------------------------------------------------------
  // Status lamps
  // ----------------------------------------------------------------
  for (genvar k = 0; k < LAMP_N; k++) begin : g_lamp
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lamp_q[k] <= 1'b1;
      end else begin
        lamp_q[k] <= ~(lamp_on[k] | ctrl_q[CTRL_LAMP_TEST]);
      end
    end
    assign lamp_oe[k] = run;
  end

  assign status_lamp1_n_o = lamp_q[0];
  assign status_lamp2_n_o = lamp_q[1];
  assign status_lamp3_n_o = lamp_q[2];
  assign status_lamp4_n_o = lamp_q[3];
  assign status_lamp5_n_o = lamp_q[4];
  assign status_lamp1_n_oe = lamp_oe[0];
  assign status_lamp2_n_oe = lamp_oe[1];
  assign status_lamp3_n_oe = lamp_oe[2];
  assign status_lamp4_n_oe = lamp_oe[3];
  assign status_lamp5_n_oe = lamp_oe[4];

  // Address bit 0 pin becomes an output
  assign phy_addr_strap0_o = ADDR0_RUN_LVL;
  assign phy_addr_strap0_oe = run;

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  assign pending = |(stat_q & mask_q);
  assign irq = pending;

  assign port_irq_n_o = 1'b0;
  assign port_irq_n_oe = run & pending & ctrl_q[CTRL_IRQ_PIN_EN];

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_acc;
  logic setup;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STRAP) ||
                  (paddr == OFF_STAT) || (paddr == OFF_MASK);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_acc && paddr == OFF_CTRL) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (wr_acc && paddr == OFF_MASK) begin
      mask_q <= pwdata[EVT_W-1:0];
    end
  end

  // Write one to clear; a new event in the same cycle keeps its bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else if (wr_acc && paddr == OFF_STAT) begin
      stat_q <= (stat_q & ~pwdata[EVT_W-1:0]) | evt;
    end else begin
      stat_q <= stat_q | evt;
    end
  end

  // Read data is loaded in the setup cycle so it comes from a flop.
  // Strap word is read-only; writes to it are ignored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= '0;
      case (paddr)
        OFF_CTRL: prdata_q[CTRL_W-1:0] <= ctrl_q;
        OFF_STRAP: begin
          prdata_q[STRAP_ADDR_LSB +: PHY_ADDR_W] <= straps_q.phy_addr;
          prdata_q[STRAP_REF_BIT] <= straps_q.ref_src;
          prdata_q[STRAP_ISO_BIT] <= straps_q.super_iso;
          prdata_q[STRAP_FW_BIT] <= straps_q.fw_rom;
        end
        OFF_STAT: prdata_q[EVT_W-1:0] <= stat_q;
        OFF_MASK: prdata_q[EVT_W-1:0] <= mask_q;
        default: prdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_HOLD_UNDRIVEN: assert property (
    phase_q == SSP_PH_HOLD |-> !(|lamp_oe) && !phy_addr_strap0_oe && !port_irq_n_oe)
    else $error("shared pin driven before strap capture");

  AST_ADDR_CAPTURE: assert property (
    $rose(run) |-> straps.phy_addr ==
    {$past(status_lamp3_n_i), $past(phy_addr_strap_mid),
     $past(status_lamp1_n_i), $past(phy_addr_strap0_i)})
    else $error("address strap not captured at release");

  AST_REF_XTAL: assert property (
    $rose(run) && $past(status_lamp2_n_i) |->
    straps.ref_src == SSP_REF_XTAL_156M25 && ref_freq_khz == REF_XTAL_KHZ)
    else $error("high reference strap did not pick crystal");

  AST_REF_EXT: assert property (
    $rose(run) && !$past(status_lamp2_n_i) |->
    straps.ref_src == SSP_REF_EXT_50M && ref_freq_khz == REF_EXT_KHZ)
    else $error("low reference strap did not pick 50 MHz source");

  AST_RUN_DRIVES: assert property (
    run |-> (&lamp_oe) && phy_addr_strap0_oe)
    else $error("shared pin not driven after reset");

  AST_LAMP_LOW: assert property (
    run && $past(run) |->
    lamp_q == ~($past(lamp_on) | {LAMP_N{$past(ctrl_q[CTRL_LAMP_TEST])}}))
    else $error("lamp output not active low");

  AST_SUPER_ISO: assert property (
    $rose(run) |-> super_isolate == $past(status_lamp5_n_i) ##1 $stable(super_isolate))
    else $error("super isolation does not follow strap");

  AST_IRQ_PIN: assert property (
    run && ctrl_q[CTRL_IRQ_PIN_EN] |->
    (port_irq_n_oe && !port_irq_n_o) == (|(stat_q & mask_q)))
    else $error("interrupt pin does not track pending state");

  AST_IRQ_RELEASE: assert property (
    !(|(stat_q & mask_q)) |-> !port_irq_n_oe)
    else $error("interrupt pin pulled with nothing pending");

  AST_STAT_SET_WINS: assert property (
    wr_acc && paddr == OFF_STAT |=> (stat_q & $past(evt)) == $past(evt))
    else $error("status event lost to a same-cycle clear");

  AST_FW_SRC: assert property (
    $rose(run) |-> fw_from_rom == $past(port_irq_n_i) && fw_from_mgmt != fw_from_rom)
    else $error("firmware source not taken from strap");

  AST_FW_EXCLUSIVE: assert property (
    run |-> fw_from_rom != fw_from_mgmt)
    else $error("firmware paths not exclusive");

  AST_STRAP_READ: assert property (
    run && psel && !penable && paddr == OFF_STRAP |=>
    prdata[STRAP_ADDR_LSB +: PHY_ADDR_W] == straps.phy_addr)
    else $error("strap word does not show the captured address");

  AST_STRAPS_HELD: assert property (
    run && $past(run) |-> $stable(straps) && $stable(ref_freq_khz))
    else $error("strap setting changed after capture");

  AST_EFFECTS_HELD: assert property (
    run && $past(run) |-> $stable(super_isolate) && $stable(fw_from_rom))
    else $error("decoded strap effect changed after capture");

endmodule : ssp_strap_pins

/* test/ssp_board.sv */
// Board model for the shared pins: pull resistors and the block's pin drivers.
// Assumes pin order addr0, lamp1..lamp5, interrupt in every vector.
`timescale 1ns/1ns
module ssp_board (
  input wire logic [6:0] pull,
  input wire logic [6:0] pin_o,
  input wire logic [6:0] pin_oe,
  output logic [6:0] lvl
);
  // pulls only, no active driver
  // A released pin settles to its pull, never to a stale level
  assign lvl = (pin_oe & pin_o) | (~pin_oe & pull);
endmodule : ssp_board

/* test/tb_ssp_strap_pins.sv */
// Self-checking bench for the strap-sample and status-pin block.
// Assumes the board model resolves every released shared pin from its pull level.
`timescale 1ns/1ns
module tb_ssp_strap_pins;
  import ssp_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] pull, pin_o, pin_oe, lvl;
  logic [1:0] mid;
  logic [4:0] lamp_on;
  logic [3:0] evt;
  ssp_strap_t straps;
  logic [FREQ_W-1:0] ref_freq_khz;
  logic super_isolate, fw_from_rom, fw_from_mgmt, irq;
  int errors, check_count, cyc;

  ssp_strap_pins uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .phy_addr_strap0_i(lvl[0]), .phy_addr_strap0_o(pin_o[0]), .phy_addr_strap0_oe(pin_oe[0]),
    .phy_addr_strap_mid(mid),
    .status_lamp1_n_i(lvl[1]), .status_lamp1_n_o(pin_o[1]), .status_lamp1_n_oe(pin_oe[1]),
    .status_lamp2_n_i(lvl[2]), .status_lamp2_n_o(pin_o[2]), .status_lamp2_n_oe(pin_oe[2]),
    .status_lamp3_n_i(lvl[3]), .status_lamp3_n_o(pin_o[3]), .status_lamp3_n_oe(pin_oe[3]),
    .status_lamp4_n_i(lvl[4]), .status_lamp4_n_o(pin_o[4]), .status_lamp4_n_oe(pin_oe[4]),
    .status_lamp5_n_i(lvl[5]), .status_lamp5_n_o(pin_o[5]), .status_lamp5_n_oe(pin_oe[5]),
    .port_irq_n_i(lvl[6]), .port_irq_n_o(pin_o[6]), .port_irq_n_oe(pin_oe[6]),
    .lamp_on(lamp_on), .evt(evt), .straps(straps), .ref_freq_khz(ref_freq_khz),
    .super_isolate(super_isolate), .fw_from_rom(fw_from_rom),
    .fw_from_mgmt(fw_from_mgmt), .irq(irq)
  );

  ssp_board board (.pull(pull), .pin_o(pin_o), .pin_oe(pin_oe), .lvl(lvl));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Let the edge's updates land before looking
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No limit of its own: pready or the bench timeout ends the wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic strap_reset(input logic [6:0] pp, input logic [1:0] m);
    logic [4:0] a;
    logic [31:0] sv;
    a = {pp[3], m, pp[1], pp[0]};
    @(posedge clk);
    rst <= 1'b1;
    pull <= pp;
    mid <= m;
    repeat (4) @(posedge clk);
    chk("oe_in_reset", pin_oe, 7'h00);
    rst <= 1'b0;
    tick(2);
    chk("straps", straps, {a, pp[2], pp[5], pp[6]});
    chk("ref_khz", ref_freq_khz, pp[2] ? REF_XTAL_KHZ : REF_EXT_KHZ);
    chk("isolate", super_isolate, pp[5]);
    chk("fw_src", {fw_from_rom, fw_from_mgmt}, {pp[6], ~pp[6]});
    chk("oe_run", pin_oe[5:0], 6'h3f);
    chk("addr0_pin", lvl[0], ADDR0_RUN_LVL);
    @(posedge clk);
    pull <= ~pp;
    mid <= ~m;
    tick(2);
    chk("straps_held", straps, {a, pp[2], pp[5], pp[6]});
    apb(1'b0, OFF_STRAP, 32'h0);
    sv = rd;
    chk("strap_reg", sv, {24'h0, pp[6], pp[5], pp[2], a});
    // Monitor-only word: write back exactly what was read
    apb(1'b1, OFF_STRAP, sv);
    apb(1'b0, OFF_STRAP, 32'h0);
    chk("strap_rmw", rd, sv);
  endtask : strap_reset

  task automatic lamps();
    @(posedge clk);
    lamp_on <= 5'h15;
    tick(2);
    chk("lamps", lvl[5:1], 5'h0a);
    apb(1'b1, OFF_CTRL, 32'h3);
    tick(2);
    chk("lamp_test", lvl[5:1], 5'h00);
    apb(1'b1, OFF_CTRL, 32'h2);
  endtask : lamps

  task automatic interrupt();
    // Pull the interrupt pin up so that a release shows on it
    @(posedge clk);
    pull <= pull | 7'h40;
    apb(1'b1, OFF_MASK, 32'h1);
    @(posedge clk);
    evt <= 4'h3;
    @(posedge clk);
    evt <= 4'h0;
    tick(2);
    chk("irq", irq, 1'b1);
    chk("irq_pin", lvl[6], 1'b0);
    apb(1'b1, OFF_CTRL, 32'h0);
    tick(1);
    chk("irq_pin_off", {irq, lvl[6]}, 2'h3);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat", rd, 32'h3);
    apb(1'b1, OFF_MASK, 32'h0);
    tick(1);
    chk("irq_masked", {irq, lvl[6]}, 2'h1);
    apb(1'b1, OFF_MASK, 32'h1);
    apb(1'b1, OFF_STAT, 32'h1);
    tick(1);
    chk("irq_clear", {irq, lvl[6]}, 2'h1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_left", rd, 32'h2);
    // Event held across the clearing write: the set must win
    @(posedge clk);
    evt <= 4'h2;
    apb(1'b1, OFF_STAT, 32'h2);
    evt <= 4'h0;
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_set_wins", rd, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {er, rd}, {1'b1, 32'h0});
  endtask : interrupt

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pull = 7'h55;
    mid = 2'h2;
    lamp_on = 5'h00;
    evt = 4'h0;
    errors = 0;
    check_count = 0;
    cyc = 0;
    strap_reset(7'h55, 2'h2);
    lamps();
    interrupt();
    // Second reset in mid-run with every strap inverted
    strap_reset(7'h2a, 2'h1);
    interrupt();
    conclude();
  end
endmodule : tb_ssp_strap_pins
